// >>> rtl/eiav_pkg.sv
package eiav_pkg;
  localparam int          MASK_W        = 3;
  localparam int          VEC_W         = 8;
  localparam int          ADDR_W        = 24;
  localparam int          SYNC_W        = 18;
  localparam int          STACK_DEPTH   = 8;
  localparam int          PTR_W         = 3;
  localparam int          VBR_LSB       = 10;
  localparam int          IRQ_LSB       = 10;
  localparam int          STRAP_BIT     = 10;
  localparam int          SIZE_ACK_STROBE_BIT     = 9;
  localparam int          AUTOVECTOR_STROBE_BIT      = 8;
  localparam logic [17:0] SYNC_IDLE     = 18'h3_FF00;
  localparam logic [2:0]  MASK_RESET    = 3'h7;
  localparam logic [2:0]  LEVEL_NMI     = 3'h7;
  localparam logic [2:0]  LEVEL_NONE    = 3'h0;
  localparam logic [2:0]  FC_CPU_SPACE  = 3'h7;
  localparam logic [3:0]  ARB_NONE      = 4'h0;
  localparam logic [3:0]  ACK_WAIT      = 4'h3;
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;
  localparam logic [15:0] CS_AUTOVECTOR_STROBE_BASE  = 16'hFFF8;
  localparam logic        CS_MODE_ASYNC = 1'h0;
  localparam logic [1:0]  CS_BYTE_BOTH  = 2'h3;
  localparam logic [1:0]  CS_RW_BOTH    = 2'h3;
  localparam logic        CS_STROBE_SYNC_SELECT_AS    = 1'h0;
  localparam logic [1:0]  CS_SPACE_CPU  = 2'h0;
  localparam logic        CS_AUTOVECTOR_STROBE_ON    = 1'h1;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_FETCH} eiav_state_type;
endpackage : eiav_pkg

// >>> rtl/eiav_top.sv
`timescale 1ns/100ps
module eiav_top #(
  parameter logic [7:0] AUTOVEC_BASE = 8'h18
) (
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_rst_b,
  // Request pins and strap
  input  wire logic [7:1]          i_irq_b,
  input  wire logic                i_data9_strap,
  input  wire logic [7:1]          i_pin_assign_irq,
  // Acknowledge bus
  input  wire logic [7:0]          i_data,
  input  wire logic                i_size_ack_strobe_b,
  input  wire logic                i_autovector_strobe_b,
  output logic                     o_addr_strobe_b,
  output logic [23:0]              o_addr,
  output logic [2:0]               o_fc,
  // Acknowledge chip select
  input  wire logic [15:0]         i_cs_base,
  input  wire logic                i_cs_async_mode,
  input  wire logic [1:0]          i_cs_byte,
  input  wire logic [1:0]          i_cs_rw,
  input  wire logic                i_cs_strobe_sync_select,
  input  wire logic [1:0]          i_cs_space,
  input  wire logic                i_cs_autovector_strobe_en,
  input  wire logic                i_cs_size_ack_en,
  // Processor control
  input  wire logic [2:0]          i_mask_wdata,
  input  wire logic                i_mask_wr,
  input  wire logic                i_return_from_exception,
  input  wire logic [31:0]         i_vector_base,
  input  wire logic [3:0]          i_arb_number,
  // Internal module request
  input  wire logic [2:0]          i_mod_level,
  input  wire logic [3:0]          i_mod_arb,
  input  wire logic [7:0]          i_mod_vector,
  // Vector fetch
  output logic                     o_fetch_req,
  output logic [31:0]              o_vector_addr,
  input  wire logic                i_fetch_ack,
  input  wire logic [31:0]         i_fetch_data,
  // Results
  output logic [2:0]               o_priority_mask,
  output logic                     o_push_status,
  output logic [3:0]               o_status_word,
  output logic                     o_context_save,
  output logic                     o_pc_load,
  output logic [31:0]              o_pc,
  output logic                     o_autovector,
  output logic [7:1]               o_pins_are_irq
);
  import eiav_pkg::*;

  logic [SYNC_W-1:0]    sync1_r;
  logic [SYNC_W-1:0]    sync2_r;
  logic                 nonmaskable_request_d_r;
  logic [1:0]           strap_cnt_r;
  logic                 nmi_pend_r;
  logic                 in_l7_r;
  logic [3:0]           stack_mem [STACK_DEPTH];
  logic [PTR_W:0]       ptr_r;
  eiav_state_type       state_r;
  logic [3:0]           ack_cnt_r;
  logic [2:0]           level_r;
  logic [7:1]           irq_act;
  logic [2:0]           ext_lvl;
  logic                 ext_ok;
  logic                 mod_ok;
  logic                 pick_mod;
  logic                 accept;
  logic [2:0]           acc_lvl;
  logic                 nonmaskable_request_low;
  logic                 nmi_fall;
  logic                 do_rte;
  logic [3:0]           top;
  logic                 cs_autovector_strobe;
  logic                 term_autovector_strobe;
  logic                 term_size_ack_strobe;
  logic [7:0]           vec;

  // Sync pins: two flops before any use
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
      nonmaskable_request_d_r <= 1'b1;
    end else begin
      sync1_r <= {i_irq_b, i_data9_strap, i_size_ack_strobe_b, i_autovector_strobe_b, i_data};
      sync2_r <= sync1_r;
      nonmaskable_request_d_r <= sync2_r[IRQ_LSB+7];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_cnt_r <= 2'h0;
      o_pins_are_irq <= 7'h00;
    end else if (strap_cnt_r != STRAP_WAIT) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      o_pins_are_irq <= {7{sync2_r[STRAP_BIT]}};
    end else begin
      o_pins_are_irq <= i_pin_assign_irq;
    end
  end

  genvar g;
  generate
    for (g = 1; g <= 7; g++) begin : g_act
      assign irq_act[g] = !sync2_r[IRQ_LSB+g] && o_pins_are_irq[g];
    end
  endgenerate

  assign nonmaskable_request_low = irq_act[7];
  assign nmi_fall = nonmaskable_request_low && nonmaskable_request_d_r && o_pins_are_irq[7];
  assign top      = (ptr_r != 4'h0) ? stack_mem[ptr_r[PTR_W-1:0] - 3'h1] : {1'b0, MASK_RESET};
  assign do_rte   = i_return_from_exception && (ptr_r != 4'h0) && !accept;

  always_comb begin
    ext_lvl = LEVEL_NONE;
    for (int l = 1; l <= 6; l++) begin
      if (irq_act[l]) begin
        ext_lvl = 3'(l);
      end
    end
    if (nmi_pend_r) begin
      ext_lvl = LEVEL_NMI;
    end
  end

  assign ext_ok = (ext_lvl != LEVEL_NONE) && (i_arb_number != ARB_NONE) &&
                  ((ext_lvl == LEVEL_NMI) || (ext_lvl > o_priority_mask));
  assign mod_ok = (i_mod_arb != ARB_NONE) && (i_mod_level > o_priority_mask);
  assign pick_mod = mod_ok && (!ext_ok || (i_mod_level > ext_lvl) ||
                    ((i_mod_level == ext_lvl) && (i_mod_arb > i_arb_number)));
  assign accept   = (state_r == ST_IDLE) && (ext_ok || mod_ok);
  assign acc_lvl  = pick_mod ? i_mod_level : ext_lvl;

  // edge sensing; set wins over clear
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_fall || (do_rte && nonmaskable_request_low) || (i_mask_wr && in_l7_r && nonmaskable_request_low)) begin
      nmi_pend_r <= 1'b1;
    end else if (accept && !pick_mod && (ext_lvl == LEVEL_NMI)) begin
      nmi_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_priority_mask <= MASK_RESET;
      in_l7_r <= 1'b0;
      ptr_r <= 4'h0;
      o_push_status <= 1'b0;
      o_status_word <= 4'h0;
    end else begin
      o_push_status <= accept;
      if (accept) begin
        o_status_word <= {in_l7_r, o_priority_mask};
        if (ptr_r != 4'(STACK_DEPTH)) begin
          stack_mem[ptr_r[PTR_W-1:0]] <= {in_l7_r, o_priority_mask};
          ptr_r <= ptr_r + 4'h1;
        end
        o_priority_mask <= acc_lvl;
        in_l7_r <= (acc_lvl == LEVEL_NMI);
      end else if (do_rte) begin
        o_priority_mask <= top[2:0];
        in_l7_r <= top[3];
        ptr_r <= ptr_r - 4'h1;
      end else if (i_mask_wr) begin
        o_priority_mask <= i_mask_wdata;
      end
    end
  end

  assign cs_autovector_strobe = (i_cs_base >= CS_AUTOVECTOR_STROBE_BASE) && (i_cs_async_mode == CS_MODE_ASYNC) &&
                   (i_cs_byte == CS_BYTE_BOTH) && (i_cs_rw == CS_RW_BOTH) &&
                   (i_cs_strobe_sync_select == CS_STROBE_SYNC_SELECT_AS) && (i_cs_space == CS_SPACE_CPU) &&
                   (i_cs_autovector_strobe_en == CS_AUTOVECTOR_STROBE_ON);
  assign term_autovector_strobe  = !sync2_r[AUTOVECTOR_STROBE_BIT] || cs_autovector_strobe;
  assign term_size_ack_strobe = !sync2_r[SIZE_ACK_STROBE_BIT] || (i_cs_size_ack_en && (ack_cnt_r == ACK_WAIT));
  assign vec = term_autovector_strobe ? (AUTOVEC_BASE + {5'h00, level_r}) : sync2_r[7:0];

  // Acknowledge cycle and vector fetch
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      ack_cnt_r <= 4'h0;
      level_r <= LEVEL_NONE;
      o_addr_strobe_b <= 1'b1;
      o_addr <= 24'h00_0000;
      o_fc <= 3'h0;
      o_fetch_req <= 1'b0;
      o_vector_addr <= 32'h0000_0000;
      o_context_save <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc <= 32'h0000_0000;
      o_autovector <= 1'b0;
    end else begin
      o_context_save <= 1'b0;
      o_pc_load <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (accept && pick_mod) begin
            o_vector_addr <= {i_vector_base[31:VBR_LSB], i_mod_vector, 2'b00};
            o_fetch_req <= 1'b1;
            o_context_save <= 1'b1;
            o_autovector <= 1'b0;
            state_r <= ST_FETCH;
          end else if (accept) begin
            level_r <= acc_lvl;
            ack_cnt_r <= 4'h0;
            o_addr_strobe_b <= 1'b0;
            o_addr <= {20'hF_FFFF, acc_lvl, 1'b1};
            o_fc <= FC_CPU_SPACE;
            state_r <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (ack_cnt_r != ACK_WAIT) begin
            ack_cnt_r <= ack_cnt_r + 4'h1;
          end
          if (term_autovector_strobe || term_size_ack_strobe) begin
            o_vector_addr <= {i_vector_base[31:VBR_LSB], vec, 2'b00};
            o_autovector <= term_autovector_strobe;
            o_addr_strobe_b <= 1'b1;
            o_fc <= 3'h0;
            o_fetch_req <= 1'b1;
            o_context_save <= 1'b1;
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (i_fetch_ack) begin
            o_fetch_req <= 1'b0;
            o_pc <= i_fetch_data;
            o_pc_load <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  ack_drive_ones_a: assert property (!o_addr_strobe_b |->
    (o_addr[23:4] == 20'hF_FFFF) && (o_fc == FC_CPU_SPACE)) else $error("ack address wrong");
  vec_addr_form_a: assert property ($rose(o_fetch_req) |->
    (o_vector_addr[1:0] == 2'b00) && (o_vector_addr[31:10] == $past(i_vector_base[31:10])))
    else $error("vector address malformed");
  autovec_level_a: assert property ($rose(o_fetch_req) && o_autovector |->
    o_vector_addr[9:2] == AUTOVEC_BASE + {5'h00, level_r}) else $error("autovector wrong");
  accept_mask_a: assert property (accept |=>
    o_push_status && (o_priority_mask == $past(acc_lvl))) else $error("mask not raised");
  mask_block_a: assert property (accept && (acc_lvl != LEVEL_NMI) |->
    acc_lvl > o_priority_mask) else $error("masked level taken");
  rte_restore_a: assert property (do_rte |=>
    o_priority_mask == $past(top[2:0])) else $error("mask not restored");
  nmi_edge_a: assert property (nmi_fall |=> nmi_pend_r) else $error("edge lost");
  nmi_rte_a: assert property (do_rte && nonmaskable_request_low |=> nmi_pend_r) else $error("no retrigger");
  arb_zero_a: assert property (accept && !pick_mod |->
    i_arb_number != ARB_NONE) else $error("zero arbitration taken");
  fetch_load_a: assert property (o_fetch_req && i_fetch_ack |=>
    o_pc_load && (o_pc == $past(i_fetch_data))) else $error("pc not loaded");
endmodule : eiav_top

// >>> test/eiav_periph.sv
`timescale 1ns/100ps
module eiav_periph (
  // Acknowledge bus seen from the block
  input  wire logic       i_clock,
  input  wire logic       i_strobe_b,
  input  wire logic [2:0] i_fc,
  // Mode 1 vector and size ack, 2 autovector, 0 silent
  input  wire logic [1:0] i_mode,
  input  wire logic       i_slow,
  input  wire logic [7:0] i_vector,
  // Answer
  output logic [7:0]      o_data,
  output logic            o_size_ack_b,
  output logic            o_autovector_strobe_b
);
  logic [3:0] wait_r = 4'h0;
  initial o_data = 8'h00;
  initial o_size_ack_b = 1'b1;
  initial o_autovector_strobe_b = 1'b1;
  always @(posedge i_clock) begin
    if (!i_strobe_b && i_fc == 3'h7) begin
      o_data <= i_vector;
      wait_r <= wait_r + 4'h1;
      if (wait_r == (i_slow ? 4'h6 : 4'h1)) begin
        o_size_ack_b <= (i_mode != 2'h1);
        o_autovector_strobe_b     <= (i_mode != 2'h2);
      end
    end else begin
      // Released bus keeps moving so stale data cannot pass
      o_data       <= ~o_data;
      wait_r       <= 4'h0;
      o_size_ack_b <= 1'b1;
      o_autovector_strobe_b     <= 1'b1;
    end
  end
endmodule : eiav_periph

// >>> test/eiav_top_tb.sv
`timescale 1ns/100ps
module eiav_top_tb;
  import eiav_pkg::*;
  localparam logic [7:0] AV_BASE = 8'h18;
  logic        i_clock, i_rst_b, i_data9_strap, i_size_ack_strobe_b, i_autovector_strobe_b;
  logic [7:1]  i_irq_b, i_pin_assign_irq, o_pins_are_irq;
  logic [7:0]  i_data, i_mod_vector, p_vector;
  logic [15:0] i_cs_base;
  logic [1:0]  i_cs_byte, i_cs_rw, i_cs_space, p_mode;
  logic        i_cs_async_mode, i_cs_strobe_sync_select, i_cs_autovector_strobe_en, i_cs_size_ack_en;
  logic [2:0]  i_mask_wdata, i_mod_level, o_fc, o_priority_mask;
  logic        i_mask_wr, i_return_from_exception, i_fetch_ack, p_slow;
  logic [31:0] i_vector_base, i_fetch_data, o_vector_addr, o_pc;
  logic [3:0]  i_arb_number, i_mod_arb, o_status_word;
  logic        o_addr_strobe_b, o_fetch_req, o_push_status, o_context_save, o_pc_load;
  logic        o_autovector;
  logic [23:0] o_addr;
  int          n_errors = 0;
  int          check_count = 0;

  eiav_top #(.AUTOVEC_BASE(AV_BASE)) i_dut (.i_clock, .i_rst_b, .i_irq_b, .i_data9_strap,
    .i_pin_assign_irq, .i_data, .i_size_ack_strobe_b, .i_autovector_strobe_b, .o_addr_strobe_b,
    .o_addr, .o_fc, .i_cs_base, .i_cs_async_mode, .i_cs_byte, .i_cs_rw, .i_cs_strobe_sync_select,
    .i_cs_space, .i_cs_autovector_strobe_en, .i_cs_size_ack_en, .i_mask_wdata, .i_mask_wr,
    .i_return_from_exception, .i_vector_base, .i_arb_number, .i_mod_level, .i_mod_arb,
    .i_mod_vector, .o_fetch_req, .o_vector_addr, .i_fetch_ack, .i_fetch_data, .o_priority_mask,
    .o_push_status, .o_status_word, .o_context_save, .o_pc_load, .o_pc, .o_autovector,
    .o_pins_are_irq);
  eiav_periph i_periph (.i_clock, .i_strobe_b(o_addr_strobe_b), .i_fc(o_fc), .i_mode(p_mode),
    .i_slow(p_slow), .i_vector(p_vector), .o_data(i_data), .o_size_ack_b(i_size_ack_strobe_b),
    .o_autovector_strobe_b(i_autovector_strobe_b));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task set_mask(input logic [2:0] v);
    @(posedge i_clock);
    i_mask_wdata <= v;
    i_mask_wr    <= 1'b1;
    @(posedge i_clock);
    i_mask_wr    <= 1'b0;
  endtask : set_mask

  task pop_mask(input logic [2:0] exp);
    @(posedge i_clock);
    i_return_from_exception <= 1'b1;
    @(posedge i_clock);
    i_return_from_exception <= 1'b0;
    @(negedge i_clock);
    check_val("mask after return", 32'(exp), 32'(o_priority_mask));
  endtask : pop_mask

  // One full service: request, acknowledge cycle, vector fetch, program counter load
  // Mode bit 0 set means a user vector, cleared means an autovector
  task automatic serve(input logic [2:0] lvl, input logic [1:0] mode, input logic [7:0] vec,
                       input logic rel, input logic [2:0] prev);
    int          i;
    logic [7:0]  exp_vec;
    logic [31:0] vbr;
    exp_vec = mode[0] ? vec : AV_BASE + 8'(lvl);
    vbr     = {vec, 24'h45_6FFF};
    @(posedge i_clock);
    p_mode         <= mode;
    p_vector       <= vec;
    p_slow         <= lvl[0];
    i_vector_base  <= vbr;
    i_irq_b[lvl]   <= 1'b0;
    i = 0;
    while (o_push_status !== 1'b1 && i < 40) begin
      @(negedge i_clock);
      i++;
    end
    check_val("mask on accept", 32'(lvl), 32'(o_priority_mask));
    check_val("status word", {28'h000_0000, 1'b0, prev}, 32'(o_status_word));
    check_val("ack address", {8'h00, 20'hF_FFFF, lvl, 1'b1}, 32'(o_addr));
    check_val("function code", 32'(FC_CPU_SPACE), 32'(o_fc));
    i = 0;
    while (o_fetch_req !== 1'b1 && i < 40) begin
      @(negedge i_clock);
      i++;
    end
    check_val("vector address", {vbr[31:10], exp_vec, 2'b00}, o_vector_addr);
    check_val("autovector flag", 32'(!mode[0]), 32'(o_autovector));
    check_val("context save", 32'h1, 32'(o_context_save));
    @(posedge i_clock);
    i_fetch_ack  <= 1'b1;
    i_fetch_data <= {16'h0001, vec, 8'h5A};
    @(posedge i_clock);
    i_fetch_ack  <= 1'b0;
    if (rel) i_irq_b[lvl] <= 1'b1;
    @(negedge i_clock);
    check_val("program counter", {16'h0001, vec, 8'h5A}, o_pc);
  endtask : serve

  // Internal module and external line at the same level; higher arbitration wins
  task tie_module();
    int i;
    @(posedge i_clock);
    i_arb_number  <= 4'h2;
    i_mod_level   <= 3'h3;
    i_mod_arb     <= 4'h5;
    i_mod_vector  <= 8'h9C;
    i_vector_base <= 32'hABCD_E000;
    i_irq_b[3]    <= 1'b0;
    repeat (4) @(posedge i_clock);
    set_mask(3'h2);
    i = 0;
    while (o_fetch_req !== 1'b1 && i < 40) begin
      @(negedge i_clock);
      i++;
    end
    check_val("module wins no ack cycle", 32'h1, 32'(o_addr_strobe_b));
    check_val("module vector", 32'hABCD_E270, o_vector_addr);
    check_val("module autovector flag", 32'h0, 32'(o_autovector));
    check_val("module mask", 32'h3, 32'(o_priority_mask));
    check_val("module status word", 32'hA, 32'(o_status_word));
    @(posedge i_clock);
    i_fetch_ack  <= 1'b1;
    i_fetch_data <= 32'h0002_9C00;
    i_mod_level  <= 3'h0;
    @(posedge i_clock);
    i_fetch_ack  <= 1'b0;
    i_irq_b[3]   <= 1'b1;
    @(negedge i_clock);
    check_val("module program counter", 32'h0002_9C00, o_pc);
  endtask : tie_module

  task masked_level(input logic [2:0] lvl);
    int pushes;
    pushes = 0;
    @(posedge i_clock);
    i_irq_b[lvl] <= 1'b0;
    repeat (12) begin
      @(negedge i_clock);
      pushes += int'(o_push_status === 1'b1);
    end
    check_val("pushes while masked", 32'h0, 32'(pushes));
    @(posedge i_clock);
    i_irq_b[lvl] <= 1'b1;
    repeat (4) @(posedge i_clock);
  endtask : masked_level

  initial begin
    repeat (5000) @(posedge i_clock);
    n_errors++;
    summarize();
  end

  initial begin
    {i_rst_b, i_mask_wr, i_return_from_exception, i_fetch_ack, p_slow} = 5'h00;
    {i_irq_b, i_pin_assign_irq, i_data9_strap} = {7'h7F, 7'h7F, 1'b1};
    {i_mask_wdata, i_mod_level, i_mod_arb, i_mod_vector, p_mode, p_vector} = 28'h000_0000;
    {i_vector_base, i_fetch_data, i_arb_number} = {64'h0, 4'hF};
    {i_cs_base, i_cs_async_mode, i_cs_byte, i_cs_rw} = {CS_AUTOVECTOR_STROBE_BASE, 1'b0, 2'h3, 2'h3};
    {i_cs_strobe_sync_select, i_cs_space, i_cs_autovector_strobe_en, i_cs_size_ack_en} = 5'h00;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (8) @(negedge i_clock);
    check_val("mask out of reset", 32'h7, 32'(o_priority_mask));
    check_val("pin function", 32'h7F, 32'(o_pins_are_irq));
    set_mask(3'h0);
    serve(3'h3, 2'h1, 8'h40, 1'b1, 3'h0);
    pop_mask(3'h0);
    set_mask(3'h6);
    masked_level(3'h5);
    set_mask(3'h4);
    serve(3'h5, 2'h2, 8'h00, 1'b1, 3'h4);
    pop_mask(3'h4);
    set_mask(3'h1);
    @(posedge i_clock);
    i_cs_autovector_strobe_en <= CS_AUTOVECTOR_STROBE_ON;
    serve(3'h2, 2'h0, 8'h00, 1'b1, 3'h1);
    i_cs_autovector_strobe_en <= 1'b0;
    pop_mask(3'h1);
    @(posedge i_clock);
    i_cs_size_ack_en <= 1'b1;
    serve(3'h4, 2'h3, 8'h66, 1'b1, 3'h1);
    i_cs_size_ack_en <= 1'b0;
    pop_mask(3'h1);
    set_mask(3'h7);
    serve(3'h7, 2'h1, 8'hC7, 1'b0, 3'h7);
    @(posedge i_clock);
    i_return_from_exception <= 1'b1;
    @(posedge i_clock);
    i_return_from_exception <= 1'b0;
    serve(3'h7, 2'h1, 8'hC8, 1'b1, 3'h7);
    tie_module();
    summarize();
  end
endmodule : eiav_top_tb
